/* panel_data_pkg.sv */
// Constants for the operator panel shared data area.
// Assumes a word-addressed register port; offsets are word indices.
package panel_data_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] OFF_SCREEN_CHANGE = 5'h08;
  localparam logic [4:0] OFF_DISPLAY_ONOFF = 5'h09;
  localparam logic [4:0] OFF_YEAR_SET = 5'h0A;
  localparam logic [4:0] OFF_MONTH_SET = 5'h0B;
  localparam logic [4:0] OFF_DATE_SET = 5'h0C;
  localparam logic [4:0] OFF_TIME_SET = 5'h0D;
  localparam logic [4:0] OFF_CONTROL = 5'h0E;
  localparam logic [4:0] OFF_RESERVED = 5'h0F;
  localparam logic [4:0] OFF_WIN_CONTROL = 5'h10;
  localparam logic [4:0] OFF_WIN_SELECT = 5'h11;
  localparam logic [4:0] OFF_WIN_POS_X = 5'h12;
  localparam logic [4:0] OFF_WIN_POS_Y = 5'h13;
  localparam logic [4:0] OFF_STATUS = 5'h06;
  localparam logic [4:0] OFF_DISP_SCREEN = 5'h00;
  localparam logic [15:0] DISPLAY_OFF_CODE = 16'hFFFF;
  localparam logic [15:0] DISPLAY_ON_CODE = 16'h0000;
  localparam logic [15:0] SCREEN_MIN = 16'h0001;
  localparam logic [15:0] SCREEN_MAX_BIN = 16'h2327;
  localparam logic [15:0] SCREEN_MAX_BCD = 16'h1999;
  localparam int YEAR_FLAG_BIT = 15;
  localparam int CTL_BACKLIGHT_OFF = 0;
  localparam int CTL_BUZZER_ON = 1;
  localparam int CTL_PRINT_START = 2;
  localparam int CTL_BUZZER_DIS = 4;
  localparam int CTL_AUX_DIS = 5;
  localparam int CTL_EXCLUSIVE = 7;
  localparam int CTL_VIDEO_FULL = 8;
  localparam int CTL_HARDCOPY_DIS = 11;
  localparam logic [15:0] CTL_MASK = 16'h09B7;
  localparam int ST_PRINTING = 2;
  localparam int ST_SET_TOGGLE = 3;
  localparam int ST_EXCLUSIVE = 7;
  localparam int ST_ENTRY_ERR = 8;
  localparam int ST_DISPLAY_OFF = 9;
  localparam int WIN_SHOW = 0;
  localparam int WIN_LOCK_ORDER = 1;
  localparam logic [15:0] WIN_MASK = 16'h0003;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_SCREEN = 16'h0001;
  localparam int STANDBY_CYCLES = 1000;
endpackage : panel_data_pkg

/* operator_panel_shared_data_area.sv */
// Shared system data area of an operator panel, seen from the panel.
// Assumes a word-addressed register port on the single 125 MHz clock;
// panel-side events arrive as asynchronous pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module operator_panel_shared_data_area #(
  parameter int STANDBY_TICKS = panel_data_pkg::STANDBY_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [panel_data_pkg::ADDR_W-1:0] regAddr,
  input wire logic [panel_data_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [panel_data_pkg::DATA_W-1:0] regRdData,
  input wire logic bcdInputMode,
  input wire logic standbyEnable,
  input wire logic touchActivity,
  input wire logic printBusy,
  input wire logic keypadEntry,
  input wire logic entryOutOfRange,
  input wire logic exclusiveSession,
  output logic displayOn,
  output logic backlightOn,
  output logic touchEnable,
  output logic buzzerDrive,
  output logic printStart,
  output logic auxOutEnable,
  output logic videoFullEnable,
  output logic hardcopyDisable,
  output logic exclusiveGrant,
  output logic [15:0] activeScreen,
  output logic screenChanged,
  output logic clockLoad,
  output logic [15:0] clockYear,
  output logic [15:0] clockMonth,
  output logic [15:0] clockDate,
  output logic [15:0] clockTime,
  output logic windowShow,
  output logic windowOrderLock,
  output logic [15:0] windowSelect,
  output logic [15:0] windowPosX,
  output logic [15:0] windowPosY
);
  import panel_data_pkg::*;

  // Three-stage synchroniser for the pin inputs
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA_ff;
  logic [NSYNC-1:0] syncB_ff;
  logic [NSYNC-1:0] syncC_ff;
  logic [NSYNC-1:0] pinStable_ff;
  logic [NSYNC-1:0] nxt_pinStable;
  assign pinRaw = {exclusiveSession, entryOutOfRange, keypadEntry, printBusy,
                   touchActivity, standbyEnable};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : gSync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
          syncC_ff[gi] <= 1'b0;
          pinStable_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= pinRaw[gi];
          syncB_ff[gi] <= syncA_ff[gi];
          syncC_ff[gi] <= syncB_ff[gi];
          pinStable_ff[gi] <= nxt_pinStable[gi];
        end
      end
      assign nxt_pinStable[gi] = (syncB_ff[gi] == syncC_ff[gi]) ? syncC_ff[gi]
                                                                : pinStable_ff[gi];
    end
  endgenerate

  wire standbyOn = pinStable_ff[0];
  wire touchNow = pinStable_ff[1];
  wire printNow = pinStable_ff[2];
  wire keypadNow = pinStable_ff[3];
  wire rangeBad = pinStable_ff[4];
  wire exclNow = pinStable_ff[5];

  logic [NSYNC-1:0] pinPrev_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pinPrev_ff <= '0;
    else pinPrev_ff <= pinStable_ff;
  end
  wire touchRise = touchNow && !pinPrev_ff[1];
  wire keypadRise = keypadNow && !pinPrev_ff[3];

  // Address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  wire wrScreen = regWrite && hit(regAddr, OFF_SCREEN_CHANGE);
  wire wrOnOff = regWrite && hit(regAddr, OFF_DISPLAY_ONOFF);
  wire wrYear = regWrite && hit(regAddr, OFF_YEAR_SET);
  wire wrMonth = regWrite && hit(regAddr, OFF_MONTH_SET);
  wire wrDate = regWrite && hit(regAddr, OFF_DATE_SET);
  wire wrTime = regWrite && hit(regAddr, OFF_TIME_SET);
  wire wrCtl = regWrite && hit(regAddr, OFF_CONTROL);
  wire wrWin = regWrite && hit(regAddr, OFF_WIN_CONTROL);
  wire wrWinSel = regWrite && hit(regAddr, OFF_WIN_SELECT);
  wire wrWinX = regWrite && hit(regAddr, OFF_WIN_POS_X);
  wire wrWinY = regWrite && hit(regAddr, OFF_WIN_POS_Y);

  // Screen number range check
  function automatic logic isBcd(input logic [15:0] v);
    isBcd = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) && (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
  endfunction : isBcd

  wire screenValid = bcdInputMode ?
                     (isBcd(regWrData) && regWrData >= SCREEN_MIN && regWrData <= SCREEN_MAX_BCD)
                   : (regWrData >= SCREEN_MIN && regWrData <= SCREEN_MAX_BIN);
  wire screenTake = wrScreen && screenValid;

  // Stored words
  logic [15:0] screenReq_ff;
  logic [15:0] onOffWord_ff;
  logic [15:0] yearSet_ff;
  logic [15:0] monthSet_ff;
  logic [15:0] dateSet_ff;
  logic [15:0] timeSet_ff;
  logic [15:0] ctl_ff;
  logic [15:0] winCtl_ff;
  logic [15:0] winSel_ff;
  logic [15:0] winX_ff;
  logic [15:0] winY_ff;

  // Screen request and on/off word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      screenReq_ff <= RESET_SCREEN;
      onOffWord_ff <= RESET_WORD;
    end else begin
      if (screenTake) screenReq_ff <= regWrData;
      if (wrOnOff) onOffWord_ff <= regWrData;
    end
  end

  // Clock set words, copied to the clock only on a flag change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      yearSet_ff <= RESET_WORD;
      monthSet_ff <= RESET_WORD;
      dateSet_ff <= RESET_WORD;
      timeSet_ff <= RESET_WORD;
    end else begin
      if (wrYear) yearSet_ff <= regWrData;
      if (wrMonth) monthSet_ff <= regWrData;
      if (wrDate) dateSet_ff <= regWrData;
      if (wrTime) timeSet_ff <= regWrData;
    end
  end

  // Control word, reserved bits dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= RESET_WORD;
    end else begin
      if (wrCtl) ctl_ff <= regWrData & CTL_MASK;
    end
  end

  // Window words
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      winCtl_ff <= RESET_WORD;
      winSel_ff <= RESET_WORD;
      winX_ff <= RESET_WORD;
      winY_ff <= RESET_WORD;
    end else begin
      if (wrWin) winCtl_ff <= regWrData & WIN_MASK;
      if (wrWinSel) winSel_ff <= regWrData;
      if (wrWinX) winX_ff <= regWrData;
      if (wrWinY) winY_ff <= regWrData;
    end
  end

  logic displayOn_ff;
  logic nxt_displayOn;

  // Stand-by timer: counts while the panel sits idle with the display on
  localparam int SB_W = $clog2(STANDBY_TICKS + 1);
  logic [SB_W-1:0] standby_ff;
  logic [SB_W-1:0] nxt_standby;
  wire standbyExpire = standbyOn && displayOn_ff && (standby_ff == SB_W'(STANDBY_TICKS - 1));
  // Touch or any register write restarts the idle count
  assign nxt_standby = (!standbyOn || !displayOn_ff || touchRise || regWrite || standbyExpire)
                       ? '0 : standby_ff + SB_W'(1);

  // Display state and status bit 9
  wire blankReq = (wrOnOff && regWrData == DISPLAY_OFF_CODE) || standbyExpire;
  wire unblankReq = (wrOnOff && regWrData == DISPLAY_ON_CODE) || screenTake
                    || touchRise;
  always_comb begin
    nxt_displayOn = displayOn_ff;
    if (blankReq) nxt_displayOn = 1'b0;
    else if (unblankReq) nxt_displayOn = 1'b1;
  end
  // Backlight bit deliberately absent from the display state above

  // Clock load on any flag edge
  logic yearFlagPrev_ff;
  wire flagChange = yearSet_ff[YEAR_FLAG_BIT] != yearFlagPrev_ff;

  // Status bits
  logic setToggle_ff;
  logic entryErr_ff;
  logic screenTake_ff;
  wire nxt_setToggle = keypadRise ? ~setToggle_ff : setToggle_ff;
  wire nxt_entryErr = keypadRise ? rangeBad : (screenTake ? 1'b0 : entryErr_ff);
  logic [15:0] statusWord;
  always_comb begin
    statusWord = RESET_WORD;
    statusWord[ST_PRINTING] = printNow;
    statusWord[ST_SET_TOGGLE] = setToggle_ff;
    statusWord[ST_EXCLUSIVE] = exclNow;
    statusWord[ST_ENTRY_ERR] = entryErr_ff;
    statusWord[ST_DISPLAY_OFF] = !displayOn_ff;
  end

  logic [15:0] nxt_rdData;
  always_comb begin
    case (regAddr)
      OFF_DISP_SCREEN: nxt_rdData = screenReq_ff;
      OFF_STATUS: nxt_rdData = statusWord;
      OFF_SCREEN_CHANGE: nxt_rdData = screenReq_ff;
      OFF_DISPLAY_ONOFF: nxt_rdData = onOffWord_ff;
      OFF_YEAR_SET: nxt_rdData = yearSet_ff;
      OFF_MONTH_SET: nxt_rdData = monthSet_ff;
      OFF_DATE_SET: nxt_rdData = dateSet_ff;
      OFF_TIME_SET: nxt_rdData = timeSet_ff;
      OFF_CONTROL: nxt_rdData = ctl_ff;
      OFF_WIN_CONTROL: nxt_rdData = winCtl_ff;
      OFF_WIN_SELECT: nxt_rdData = winSel_ff;
      OFF_WIN_POS_X: nxt_rdData = winX_ff;
      OFF_WIN_POS_Y: nxt_rdData = winY_ff;
      default: nxt_rdData = RESET_WORD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      standby_ff <= '0;
      displayOn_ff <= 1'b1;
      yearFlagPrev_ff <= 1'b0;
      setToggle_ff <= 1'b0;
      entryErr_ff <= 1'b0;
      screenTake_ff <= 1'b0;
    end else begin
      standby_ff <= nxt_standby;
      displayOn_ff <= nxt_displayOn;
      yearFlagPrev_ff <= yearSet_ff[YEAR_FLAG_BIT];
      setToggle_ff <= nxt_setToggle;
      entryErr_ff <= nxt_entryErr;
      screenTake_ff <= screenTake;
    end
  end

  // Read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= RESET_WORD;
    end else begin
      regRdData <= regRead ? nxt_rdData : RESET_WORD;
    end
  end

  // Display and touch follow the display state, never the backlight
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      displayOn <= 1'b1;
      touchEnable <= 1'b1;
    end else begin
      displayOn <= displayOn_ff;
      touchEnable <= displayOn_ff;
    end
  end

  // Control word decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      backlightOn <= 1'b1;
      buzzerDrive <= 1'b0;
      printStart <= 1'b0;
      auxOutEnable <= 1'b1;
      videoFullEnable <= 1'b0;
      hardcopyDisable <= 1'b0;
      exclusiveGrant <= 1'b0;
    end else begin
      backlightOn <= !ctl_ff[CTL_BACKLIGHT_OFF];
      buzzerDrive <= ctl_ff[CTL_BUZZER_ON] && !ctl_ff[CTL_BUZZER_DIS];
      printStart <= ctl_ff[CTL_PRINT_START] && !ctl_ff[CTL_HARDCOPY_DIS];
      auxOutEnable <= !ctl_ff[CTL_AUX_DIS];
      videoFullEnable <= ctl_ff[CTL_VIDEO_FULL];
      hardcopyDisable <= ctl_ff[CTL_HARDCOPY_DIS];
      exclusiveGrant <= ctl_ff[CTL_EXCLUSIVE];
    end
  end

  // Change pulse lines up with the new screen number
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      activeScreen <= RESET_SCREEN;
      screenChanged <= 1'b0;
    end else begin
      activeScreen <= screenReq_ff;
      screenChanged <= screenTake_ff;
    end
  end

  // Clock load strobe and loaded clock values
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clockLoad <= 1'b0;
      clockYear <= RESET_WORD;
      clockMonth <= RESET_WORD;
      clockDate <= RESET_WORD;
      clockTime <= RESET_WORD;
    end else begin
      clockLoad <= flagChange;
      if (flagChange) begin
        clockYear <= {8'h00, yearSet_ff[7:0]};
        clockMonth <= monthSet_ff;
        clockDate <= dateSet_ff;
        clockTime <= timeSet_ff;
      end
    end
  end

  // Window outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      windowShow <= 1'b0;
      windowOrderLock <= 1'b0;
      windowSelect <= RESET_WORD;
      windowPosX <= RESET_WORD;
      windowPosY <= RESET_WORD;
    end else begin
      windowShow <= winCtl_ff[WIN_SHOW];
      windowOrderLock <= winCtl_ff[WIN_LOCK_ORDER];
      windowSelect <= winSel_ff;
      windowPosX <= winX_ff;
      windowPosY <= winY_ff;
    end
  end
endmodule : operator_panel_shared_data_area
`default_nettype wire

/* panel_data_checker.sv */
// Port assertions for the operator panel shared data area.
// Assumes writes reach derived outputs two edges after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module panel_data_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic bcdInputMode,
  input wire logic displayOn,
  input wire logic backlightOn,
  input wire logic buzzerDrive,
  input wire logic hardcopyDisable,
  input wire logic exclusiveGrant,
  input wire logic [15:0] activeScreen,
  input wire logic screenChanged,
  input wire logic clockLoad,
  input wire logic [15:0] clockYear
);
  import panel_data_pkg::*;
  logic flag_ff;
  wire logic yrWr = regWrite && regAddr == OFF_YEAR_SET;
  wire logic ctlWr = regWrite && regAddr == OFF_CONTROL;
  wire logic dspWr = regWrite && regAddr == OFF_DISPLAY_ONOFF;
  wire logic scrWr = regWrite && regAddr == OFF_SCREEN_CHANGE && !bcdInputMode;
  wire logic scrOk = regWrData >= SCREEN_MIN && regWrData <= SCREEN_MAX_BIN;
  // Last load flag written, to spot a change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) flag_ff <= 1'b0;
    else if (yrWr) flag_ff <= regWrData[YEAR_FLAG_BIT];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_backlight_ctl:
    assert property (ctlWr |-> ##2 backlightOn == !$past(regWrData[0], 2))
    else $error("backlight wrong");
  a_ctl_decode:
    assert property (ctlWr |-> ##2 hardcopyDisable == $past(regWrData[11], 2)
      && buzzerDrive == $past(regWrData[1] && !regWrData[4], 2)) else $error("decode wrong");
  a_exclusive_grant:
    assert property (ctlWr |-> ##2 exclusiveGrant == $past(regWrData[7], 2))
    else $error("grant wrong");
  a_clock_load:
    assert property (yrWr && regWrData[15] != flag_ff |-> ##2 clockLoad
      && clockYear == ($past(regWrData, 2) & 16'h00FF)) else $error("clock not loaded");
  a_clock_hold:
    assert property (yrWr && regWrData[15] == flag_ff |-> ##2 !clockLoad)
    else $error("clock loaded without flag change");
  a_screen_take:
    assert property (scrWr && scrOk |-> ##2 screenChanged && activeScreen == $past(regWrData, 2))
    else $error("screen not taken");
  a_screen_refuse:
    assert property (scrWr && !scrOk |-> ##2 !screenChanged) else $error("screen not refused");
  a_display_blank:
    assert property (dspWr && regWrData == DISPLAY_OFF_CODE |-> ##2 !displayOn)
    else $error("display not blanked");
  a_display_wake:
    assert property (dspWr && regWrData == DISPLAY_ON_CODE |-> ##2 displayOn)
    else $error("display not on");
endmodule : panel_data_checker
bind operator_panel_shared_data_area panel_data_checker panel_data_checker_i (.clock, .rst_n,
  .regAddr, .regWrData, .regWrite, .bcdInputMode, .displayOn, .backlightOn, .buzzerDrive,
  .hardcopyDisable, .exclusiveGrant, .activeScreen, .screenChanged, .clockLoad, .clockYear);
`default_nettype wire

/* panel_controller_model.sv */
// Controller side of the register port: single-cycle word writes and reads.
// Assumes the panel answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module panel_controller_model (
  input wire logic clock,
  output logic [4:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // Clock set values go out as BCD digits
  function automatic logic [15:0] bcd2(input int n);
    return 16'((n / 10) * 16 + n % 10);
  endfunction : bcd2
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask : rd
endmodule : panel_controller_model
`default_nettype wire

/* test_operator_panel_shared_data_area.sv */
// Self-checking bench for the operator panel shared data area.
// Assumes the controller model owns the register port; panel pins driven here.
`timescale 1ns/1ps
`default_nettype none
module test_operator_panel_shared_data_area;
  import panel_data_pkg::*;
  localparam int TICKS = 20;
  localparam logic [47:0] YEARS = {16'h0097, 16'h8096, 16'h8095};
  localparam logic [95:0] SCR = {16'h0001, 16'h2000, 16'h1999, 16'h0000, 16'h2328, 16'h2327};
  localparam logic [5:0] SCR_BCD = 6'h18;
  localparam logic [5:0] SCR_OK = 6'h29;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bcdInputMode = 1'b0, standbyEnable = 1'b0, touchActivity = 1'b0, printBusy = 1'b0;
  logic keypadEntry = 1'b0, entryOutOfRange = 1'b0, exclusiveSession = 1'b0;
  logic [4:0] regAddr;
  logic [15:0] regWrData, regRdData, activeScreen, clockYear, clockMonth, clockDate, clockTime;
  logic [15:0] windowSelect, windowPosX, windowPosY, rdv;
  logic regWrite, regRead, displayOn, backlightOn, touchEnable, buzzerDrive, printStart;
  logic auxOutEnable, videoFullEnable, hardcopyDisable, exclusiveGrant, screenChanged;
  logic clockLoad, windowShow, windowOrderLock;
  logic [31:0] seed = 32'h0000003F;
  int fail_count = 0;
  int cmp_count = 0;
  wire logic [15:0] ctlSeen = {9'h000, backlightOn, buzzerDrive, printStart, auxOutEnable,
    videoFullEnable, hardcopyDisable, exclusiveGrant};
  wire logic [63:0] winSeen = {windowPosY, windowPosX, windowSelect,
    {14'h0000, windowOrderLock, windowShow}};
  always #4 clock = ~clock;
  operator_panel_shared_data_area #(.STANDBY_TICKS(TICKS)) operator_panel_shared_data_area_i (
    .clock, .rst_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .bcdInputMode,
    .standbyEnable, .touchActivity, .printBusy, .keypadEntry, .entryOutOfRange,
    .exclusiveSession, .displayOn, .backlightOn, .touchEnable, .buzzerDrive, .printStart,
    .auxOutEnable, .videoFullEnable, .hardcopyDisable, .exclusiveGrant, .activeScreen,
    .screenChanged, .clockLoad, .clockYear, .clockMonth, .clockDate, .clockTime, .windowShow,
    .windowOrderLock, .windowSelect, .windowPosX, .windowPosY);
  panel_controller_model panel_controller_model_i (.clock, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData);
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd
  function automatic logic [15:0] ctlExp(input logic [15:0] d);
    return {9'h000, !d[0], d[1] & !d[4], d[2] & !d[11], !d[5], d[8], d[11], d[7]};
  endfunction : ctlExp
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask : chkb
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    panel_controller_model_i.wr(a, d);
    cyc(2);
  endtask : w
  task automatic st(input int b, input logic e);
    panel_controller_model_i.rd(OFF_STATUS, rdv);
    chkb("statusBit", e, rdv[b]);
  endtask : st
  task automatic kp(input logic bad);
    @(posedge clock) entryOutOfRange <= bad;
    cyc(6);
    @(posedge clock) keypadEntry <= 1'b1;
    cyc(6);
    @(posedge clock) keypadEntry <= 1'b0;
    cyc(6);
  endtask : kp
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin : mainSeq
    logic [15:0] d, m, expScr;
    int k;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    cyc(2);
    chk("activeScreen", RESET_SCREEN, activeScreen);
    m = panel_controller_model_i.bcd2(1 + int'(rnd() % 16'h000C));
    w(OFF_MONTH_SET, m);
    w(OFF_TIME_SET, 16'h2157);
    w(OFF_DATE_SET, 16'h0016);
    for (int i = 0; i < 3; i++) begin
      w(OFF_YEAR_SET, YEARS[16 * i +: 16]);
      chkb("clockLoad", i != 1, clockLoad);
      chk("clockYear", YEARS[(i == 1 ? 0 : 16 * i) +: 16] & 16'h00FF, clockYear);
    end
    chk("clockMonth", m, clockMonth);
    chk("clockDate", 16'h0016, clockDate);
    chk("clockTime", 16'h2157, clockTime);
    for (int i = 0; i < 26; i++) begin
      d = (i < 16) ? 16'h0001 << i : rnd();
      w(OFF_CONTROL, d);
      chk("control", ctlExp(d), ctlSeen);
      chkb("touch", 1'b1, touchEnable && displayOn);
      panel_controller_model_i.rd(OFF_CONTROL, rdv);
      chk("controlReg", d & CTL_MASK, rdv);
    end
    for (int i = 0; i < 12; i++) begin
      k = i % 4;
      d = rnd();
      w(OFF_WIN_CONTROL + 5'(k), d);
      chk("window", k == 0 ? d & WIN_MASK : d, winSeen[16 * k +: 16]);
    end
    w(OFF_DISPLAY_ONOFF, DISPLAY_OFF_CODE);
    chkb("displayOn", 1'b0, displayOn);
    w(OFF_CONTROL, 16'h0001);
    st(9, 1'b1);
    w(OFF_DISPLAY_ONOFF, DISPLAY_ON_CODE);
    chkb("displayOn", 1'b1, displayOn);
    st(9, 1'b0);
    w(OFF_CONTROL, RESET_WORD);
    for (int i = 0; i < 3; i++) begin
      kp(i != 1);
      st(3, i != 1);
      st(8, i != 1);
    end
    w(OFF_DISPLAY_ONOFF, DISPLAY_OFF_CODE);
    expScr = RESET_SCREEN;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock) bcdInputMode <= SCR_BCD[i];
      w(OFF_SCREEN_CHANGE, SCR[16 * i +: 16]);
      if (SCR_OK[i]) expScr = SCR[16 * i +: 16];
      chkb("screenChanged", SCR_OK[i], screenChanged);
      chk("activeScreen", expScr, activeScreen);
      if (i == 0) st(8, 1'b0);
      if (i == 0) st(9, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clock) printBusy <= !i[0];
      exclusiveSession <= !i[0];
      cyc(6);
      st(2, !i[0]);
      st(7, !i[0]);
    end
    w(OFF_RESERVED, RESET_WORD);
    panel_controller_model_i.rd(5'h1F, rdv);
    chk("unmapped", RESET_WORD, rdv);
    @(posedge clock) standbyEnable <= 1'b1;
    k = 0;
    while (displayOn !== 1'b0 && k < 200) begin
      @(negedge clock);
      k++;
    end
    chkb("standbyBlank", 1'b1, k >= TICKS && k < 200);
    st(9, 1'b1);
    @(posedge clock) standbyEnable <= 1'b0;
    touchActivity <= 1'b1;
    cyc(8);
    chkb("displayOn", 1'b1, displayOn);
    st(9, 1'b0);
    finish_test();
  end
endmodule : test_operator_panel_shared_data_area
`default_nettype wire
